// file: logic/sas_pkg.sv
// Constants, register map and timing tables for the converter sequencer
`default_nettype none

package sas_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE = 16'hff80;
  localparam logic [15:0] ADDR_CHSEL = 16'hff84;
  localparam logic [15:0] ADDR_RESULT = 16'hff88;
  localparam logic [15:0] ADDR_FLAG = 16'hff8c;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CHSEL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Writable bits; the rest are held at zero and read back as zero
  localparam logic [7:0] MODE_WMASK = 8'hb8;
  localparam logic [7:0] CHSEL_WMASK = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_TIME_LSB = 3;
  localparam int TIME_W = 3;
  localparam int CHAN_W = 3;
  localparam int FLAG_BIT = 0;
  localparam int SAR_BITS = 8;

  // ----------------------------------------------------------------
  // Conversion lengths in main clock periods
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV_CYC_0 = 8'h90;
  localparam logic [7:0] CONV_CYC_1 = 8'h78;
  localparam logic [7:0] CONV_CYC_2 = 8'h60;
  localparam logic [7:0] CONV_CYC_4 = 8'h48;
  localparam logic [7:0] CONV_CYC_5 = 8'h3c;
  localparam logic [7:0] CONV_CYC_6 = 8'h30;
  localparam logic [7:0] SAMPLE_DIV = 8'h0a;

  // Prohibited codes fall back to the slowest, safest length
  function automatic logic [7:0] conv_cycles(input logic [2:0] code);
    case (code)
      3'h0: conv_cycles = CONV_CYC_0;
      3'h1: conv_cycles = CONV_CYC_1;
      3'h2: conv_cycles = CONV_CYC_2;
      3'h4: conv_cycles = CONV_CYC_4;
      3'h5: conv_cycles = CONV_CYC_5;
      3'h6: conv_cycles = CONV_CYC_6;
      default: conv_cycles = CONV_CYC_0;
    endcase
  endfunction

  // One bit step: the time left after a tenth is taken for sampling, split in eight
  function automatic logic [7:0] step_cycles(input logic [2:0] code);
    logic [7:0] t;
    t = conv_cycles(code);
    step_cycles = (t - t / SAMPLE_DIV) >> 3;
  endfunction

  // Sampling absorbs the remainder so the whole conversion is exact
  function automatic logic [7:0] sample_cycles(input logic [2:0] code);
    logic [7:0] s;
    s = step_cycles(code);
    sample_cycles = conv_cycles(code) - (s << 3);
  endfunction

endpackage

`default_nettype wire

// file: logic/sas_timer_if.sv
// Link between the sequencer core and its step timer
`timescale 1ns/1ps
`default_nettype none

interface sas_timer_if;
  logic run;
  logic start;
  logic [2:0] time_code;
  logic sampling;
  logic [2:0] bit_idx;
  logic decide;
  logic finish;

  modport core (output run, output start, output time_code,
                input sampling, input bit_idx, input decide, input finish);
  modport timer (input run, input start, input time_code,
                 output sampling, output bit_idx, output decide, output finish);
endinterface

`default_nettype wire

// file: logic/sas_sync2.sv
// Two-stage synchroniser for levels entering from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sas_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage1 = async_in;
    next_sync = stage1;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync;
    end
  end

endmodule

`default_nettype wire

// file: logic/sas_step_timer.sv
// Sample phase and bit step timing of one conversion, repeating while enabled
`timescale 1ns/1ps
`default_nettype none

module sas_step_timer (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  sas_timer_if.timer tif
);

  logic sampling;
  logic [7:0] cnt;
  logic [2:0] bit_idx;
  logic next_sampling;
  logic [7:0] next_cnt;
  logic [2:0] next_bit_idx;
  logic [7:0] samp_len;
  logic [7:0] step_len;

  always_comb begin
    samp_len = sas_pkg::sample_cycles(tif.time_code);
    step_len = sas_pkg::step_cycles(tif.time_code);
  end

  assign tif.sampling = sampling;
  assign tif.bit_idx = bit_idx;
  assign tif.decide = tif.run && !tif.start && !sampling && (cnt == step_len - 8'h01);
  assign tif.finish = tif.decide && (bit_idx == 3'h0);

  always_comb begin
    next_sampling = sampling;
    next_cnt = cnt + 8'h01;
    next_bit_idx = bit_idx;
    if (!tif.run || tif.start) begin
      // Abort or halt: next run begins again with sampling
      next_sampling = 1'b1;
      next_cnt = 8'h00;
      next_bit_idx = 3'h7;
    end else if (sampling) begin
      if (cnt == samp_len - 8'h01) begin
        next_sampling = 1'b0;
        next_cnt = 8'h00;
      end
    end else if (cnt == step_len - 8'h01) begin
      next_cnt = 8'h00;
      if (bit_idx == 3'h0) begin
        next_sampling = 1'b1;
        next_bit_idx = 3'h7;
      end else begin
        next_bit_idx = bit_idx - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sampling <= 1'b1;
      cnt <= 8'h00;
      bit_idx <= 3'h7;
    end else begin
      sampling <= next_sampling;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
    end
  end

endmodule

`default_nettype wire

// file: logic/sas_sequencer.sv
// Successive-approximation converter sequencer with its control registers
//
// Overview of operation
// - Channel select clears on reset; byte writes
// - Channel select low three bits pick input
// - Sampling takes a ninth to a fifth of conversion
// - Trial MSB at half reference, kept if not lower
// - Each lower bit tried, kept if input at or above
// - Result latched with done interrupt together
// - Conversions repeat while convert enable set
// - Control write aborts, restarts if enabled
// - Enable cleared by write stops at once
// - Result register not initialised by reset
// - Standby halts conversion sequencing
// - Coinciding read returns old result first
// - Coinciding control write suppresses result update
// - Mode write leaves done flag untouched
// - Software start only; reset in select mode
// - Mode register: enable bit seven, time bits five to three, zeros elsewhere
// - Time field selects six conversion lengths
`timescale 1ns/1ps
`default_nettype none

module sas_sequencer (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic standby_in,
  input wire logic comparator_in,
  output logic [7:0] tap_code_out,
  output logic sample_hold_out,
  output logic [2:0] channel_out,
  output logic conversion_done_irq_out,
  output logic conversion_done_flag_out,
  output logic converting_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] converter_mode;
  logic [7:0] channel_select;
  logic conversion_done_flag;
  logic [7:0] conversion_result;
  logic [7:0] approximation_reg;
  logic [7:0] next_converter_mode;
  logic [7:0] next_channel_select;
  logic next_conversion_done_flag;
  logic [7:0] next_conversion_result;
  logic [7:0] next_approximation_reg;
  logic [7:0] next_rdata;
  logic [7:0] next_tap_code;
  logic next_sample_hold;
  logic next_irq;
  logic next_converting;
  logic convert_enable;
  logic wr_mode;
  logic wr_chsel;
  logic wr_flag;
  logic ctl_wr;
  logic run;
  logic comp_sync;
  logic done_ok;
  logic [7:0] final_value;
  logic [7:0] trial_bit;

  sas_timer_if tif ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  sas_sync2 #(
    .WIDTH(1)
  ) u_comp_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(comparator_in),
    .sync_out(comp_sync)
  );

  sas_step_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .tif(tif)
  );

  // ----------------------------------------------------------------
  // Decode and control
  // ----------------------------------------------------------------
  always_comb begin
    wr_mode = reg_wr_in && (reg_addr_in == sas_pkg::ADDR_MODE);
    wr_chsel = reg_wr_in && (reg_addr_in == sas_pkg::ADDR_CHSEL);
    wr_flag = reg_wr_in && (reg_addr_in == sas_pkg::ADDR_FLAG);
    ctl_wr = wr_mode || wr_chsel;
    convert_enable = converter_mode[sas_pkg::MODE_ENABLE_BIT];
    // Standby forces the timer back to idle; it restarts cleanly afterwards
    run = convert_enable && !standby_in;
    // A control write in the completion cycle takes priority
    done_ok = tif.finish && !ctl_wr;
    trial_bit = 8'h01 << tif.bit_idx;
    final_value = tif.finish ? ((approximation_reg & ~trial_bit) | (comp_sync ? trial_bit : 8'h00))
                             : approximation_reg;
  end

  assign tif.run = run;
  assign tif.start = ctl_wr;
  assign tif.time_code = converter_mode[sas_pkg::MODE_TIME_LSB +: sas_pkg::TIME_W];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_comb begin
    next_converter_mode = converter_mode;
    next_channel_select = channel_select;
    if (wr_mode) begin
      // Reserved mode bits stay zero whatever is written
      next_converter_mode = reg_wdata_in & sas_pkg::MODE_WMASK;
    end
    if (wr_chsel) begin
      // Upper bits are dropped so a careless write cannot pick a ninth input
      next_channel_select = reg_wdata_in & sas_pkg::CHSEL_WMASK;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      converter_mode <= sas_pkg::MODE_RESET;
      channel_select <= sas_pkg::CHSEL_RESET;
    end else begin
      converter_mode <= next_converter_mode;
      channel_select <= next_channel_select;
    end
  end

  assign channel_out = channel_select[sas_pkg::CHAN_W-1:0];

  // ----------------------------------------------------------------
  // Done flag and interrupt pulse
  // ----------------------------------------------------------------
  always_comb begin
    next_conversion_done_flag = conversion_done_flag;
    // Only the flag register clears it; mode writes leave it alone
    if (wr_flag && !reg_wdata_in[sas_pkg::FLAG_BIT]) begin
      next_conversion_done_flag = 1'b0;
    end
    if (done_ok) begin
      next_conversion_done_flag = 1'b1;
    end
    next_irq = done_ok;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conversion_done_flag <= 1'b0;
      conversion_done_irq_out <= 1'b0;
    end else begin
      conversion_done_flag <= next_conversion_done_flag;
      conversion_done_irq_out <= next_irq;
    end
  end

  assign conversion_done_flag_out = conversion_done_flag;

  // ----------------------------------------------------------------
  // Approximation register and ladder drive
  // ----------------------------------------------------------------
  always_comb begin
    next_approximation_reg = approximation_reg;
    if (!run || tif.start || tif.sampling) begin
      next_approximation_reg = 8'h00;
    end else if (tif.decide) begin
      // Comparator high means input at or above the tap: keep the bit
      next_approximation_reg = final_value;
    end
    if (tif.decide) begin
      next_approximation_reg = (approximation_reg & ~trial_bit) | (comp_sync ? trial_bit : 8'h00);
      if (!run || tif.start || tif.finish) begin
        next_approximation_reg = 8'h00;
      end
    end
    next_tap_code = 8'h00;
    if (run && !tif.start && !tif.sampling) begin
      next_tap_code = approximation_reg | trial_bit;
    end
    next_sample_hold = run && tif.sampling && !tif.start;
    next_converting = run;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      approximation_reg <= 8'h00;
      tap_code_out <= 8'h00;
      sample_hold_out <= 1'b0;
      converting_out <= 1'b0;
    end else begin
      approximation_reg <= next_approximation_reg;
      tap_code_out <= next_tap_code;
      sample_hold_out <= next_sample_hold;
      converting_out <= next_converting;
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  always_comb begin
    next_conversion_result = conversion_result;
    if (done_ok) begin
      next_conversion_result = final_value;
    end
  end

  // No reset: contents are undefined until the first completion
  always_ff @(posedge clk_sys_in) begin
    conversion_result <= next_conversion_result;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = reg_rdata_out;
    if (reg_rd_in) begin
      case (reg_addr_in)
        sas_pkg::ADDR_MODE: next_rdata = converter_mode;
        sas_pkg::ADDR_CHSEL: next_rdata = channel_select;
        // Sampled before the completing edge lands, so a clash reads the old value
        sas_pkg::ADDR_RESULT: next_rdata = conversion_result;
        sas_pkg::ADDR_FLAG: next_rdata = {7'h00, conversion_done_flag};
        default: next_rdata = sas_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= sas_pkg::RDATA_RESET;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// file: tb/sas_analog_model.sv
// Behavioural sample-hold, resistor ladder and comparator seen by the sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_analog_model (
  input wire logic [63:0] levels_in,
  input wire logic [2:0] channel_in,
  input wire logic [7:0] tap_in,
  input wire logic sample_hold_in,
  output logic comparator_out
);
  logic [7:0] held;

  // ----------------------------------------------------------------
  // Hold and compare
  // ----------------------------------------------------------------
  // Level is frozen outside sampling, so late input changes do not leak in
  always_latch begin
    if (sample_hold_in) begin
      held <= levels_in[{channel_in, 3'h0} +: 8];
    end
  end

  assign comparator_out = (held >= tap_in);
endmodule

`default_nettype wire

// file: tb/sas_checker.sv
// Port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_checker (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic standby_in,
  input wire logic comparator_in,
  input wire logic [7:0] tap_code_out,
  input wire logic sample_hold_out,
  input wire logic [2:0] channel_out,
  input wire logic conversion_done_irq_out,
  input wire logic conversion_done_flag_out,
  input wire logic converting_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic ctl_wr;
  logic mode_wr;
  assign mode_wr = reg_wr_in && (reg_addr_in == sas_pkg::ADDR_MODE);
  assign ctl_wr = mode_wr || (reg_wr_in && (reg_addr_in == sas_pkg::ADDR_CHSEL));

  irq_pulse_a: assert property (conversion_done_irq_out |=> !conversion_done_irq_out)
    else $error("done pulse too long");
  irq_flag_a: assert property (conversion_done_irq_out |-> conversion_done_flag_out)
    else $error("done pulse without flag");
  flag_sticky_a: assert property (conversion_done_flag_out && !(reg_wr_in && reg_addr_in == sas_pkg::ADDR_FLAG)
    |=> conversion_done_flag_out) else $error("flag dropped");
  write_wins_a: assert property (ctl_wr |=> !conversion_done_irq_out)
    else $error("done raised beside control write");
  chsel_read_a: assert property (reg_rd_in && reg_addr_in == sas_pkg::ADDR_CHSEL |=> reg_rdata_out[7:3] == 5'h00)
    else $error("channel upper bits set");
  mode_read_a: assert property (reg_rd_in && reg_addr_in == sas_pkg::ADDR_MODE |=> (reg_rdata_out & 8'h47) == 8'h00)
    else $error("mode fixed bits set");
  // The enable lands on the write edge and the running flag is one register behind it
  stop_now_a: assert property (mode_wr && !reg_wdata_in[7] |=> ##1 (!converting_out
    && !conversion_done_irq_out && tap_code_out == 8'h00 && !sample_hold_out) [*4]) else $error("stop late");
  sample_phase_a: assert property (mode_wr && reg_wdata_in == 8'hb0 && !standby_in |=> ##1 sample_hold_out [*7]
    ##2 (!sample_hold_out && tap_code_out == 8'h80)) else $error("sample phase wrong");
  standby_halt_a: assert property (standby_in [*3] |-> !converting_out && tap_code_out == 8'h00
    && !sample_hold_out && !conversion_done_irq_out) else $error("runs in standby");
  tap_sample_a: assert property (sample_hold_out |-> tap_code_out == 8'h00)
    else $error("tap during sampling");
endmodule

bind sas_sequencer sas_checker i_sas_checker (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .standby_in(standby_in), .comparator_in(comparator_in),
  .tap_code_out(tap_code_out), .sample_hold_out(sample_hold_out), .channel_out(channel_out),
  .conversion_done_irq_out(conversion_done_irq_out), .conversion_done_flag_out(conversion_done_flag_out),
  .converting_out(converting_out));

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct {logic [2:0] ch; logic [2:0] code; logic [7:0] vin; logic [7:0] cyc;} sas_row_s;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic standby_in = 1'b0;
  logic comparator_in;
  logic [7:0] reg_rdata_out;
  logic [7:0] tap_code_out;
  logic sample_hold_out;
  logic [2:0] channel_out;
  logic conversion_done_irq_out;
  logic conversion_done_flag_out;
  logic converting_out;
  logic [63:0] levels = 64'h0;
  int n_mismatch = 0;
  int checks = 0;
  // Edges from the starting write to the visible done pulse equal the conversion time
  sas_row_s rows [8] = '{'{3'h0, 3'h0, 8'h00, 8'h90}, '{3'h1, 3'h1, 8'hff, 8'h78},
    '{3'h2, 3'h2, 8'h80, 8'h60}, '{3'h3, 3'h4, 8'h7f, 8'h48}, '{3'h4, 3'h5, 8'h01, 8'h3c},
    '{3'h5, 3'h6, 8'haa, 8'h30}, '{3'h6, 3'h3, 8'h55, 8'h90}, '{3'h7, 3'h6, 8'hc3, 8'h30}};

  always #2 clk_sys_in = ~clk_sys_in;

  sas_sequencer i_sas_sequencer (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .standby_in(standby_in), .comparator_in(comparator_in), .tap_code_out(tap_code_out),
    .sample_hold_out(sample_hold_out), .channel_out(channel_out),
    .conversion_done_irq_out(conversion_done_irq_out), .conversion_done_flag_out(conversion_done_flag_out),
    .converting_out(converting_out));

  sas_analog_model i_sas_analog_model (.levels_in(levels), .channel_in(channel_out), .tap_in(tap_code_out),
    .sample_hold_in(sample_hold_out), .comparator_out(comparator_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Counts cycles to the next done pulse; a hang ends the run
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1 n++;
      if (n > 400) begin
        n_mismatch++;
        $display("unexpected at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
        close_out();
      end
    end while (conversion_done_irq_out !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int n;
    int p;
    repeat (16) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(sas_pkg::ADDR_MODE, d);
    chk(d, sas_pkg::MODE_RESET);
    rd(sas_pkg::ADDR_CHSEL, d);
    chk(d, sas_pkg::CHSEL_RESET);
    chk({7'h0, conversion_done_flag_out}, 8'h00);
    // Awkward case: careless upper channel bits must be dropped by the hardware
    wr(sas_pkg::ADDR_CHSEL, 8'hff);
    rd(sas_pkg::ADDR_CHSEL, d);
    chk(d, 8'h07);
    wr(sas_pkg::ADDR_MODE, 8'h7f);
    rd(sas_pkg::ADDR_MODE, d);
    chk(d, 8'h38);
    chk({7'h0, converting_out}, 8'h00);
    rd(16'hff90, d);
    chk(d, 8'h00);
    $display("registers done");
    foreach (rows[i]) begin
      levels[{rows[i].ch, 3'h0} +: 8] <= rows[i].vin;
      wr(sas_pkg::ADDR_CHSEL, {5'h00, rows[i].ch});
      wr(sas_pkg::ADDR_FLAG, 8'h00);
      wr(sas_pkg::ADDR_MODE, {2'b10, rows[i].code, 3'h0});
      // First result after a start is only timed; the second is read back
      wait_irq(n);
      chk(8'(n), rows[i].cyc);
      chk({5'h00, channel_out}, {5'h00, rows[i].ch});
      wait_irq(n);
      rd(sas_pkg::ADDR_RESULT, d);
      chk(d, rows[i].vin);
      $display("row %0d done", i);
    end
    wr(sas_pkg::ADDR_MODE, 8'hb0);
    #1 chk({7'h0, conversion_done_flag_out}, 8'h01);
    wr(sas_pkg::ADDR_FLAG, 8'h01);
    #1 chk({7'h0, conversion_done_flag_out}, 8'h01);
    wr(sas_pkg::ADDR_FLAG, 8'h00);
    #1 chk({7'h0, conversion_done_flag_out}, 8'h00);
    wait_irq(n);
    wait_irq(p);
    chk(8'(p), sas_pkg::CONV_CYC_6);
    levels[63:56] <= 8'h3c;
    // The read lands in the completion cycle of the conversion now sampling
    repeat (int'(sas_pkg::CONV_CYC_6) - 2) @(posedge clk_sys_in);
    rd(sas_pkg::ADDR_RESULT, d);
    chk(d, 8'hc3);
    rd(sas_pkg::ADDR_RESULT, d);
    chk(d, 8'h3c);
    $display("collision read done");
    repeat (20) @(posedge clk_sys_in);
    wr(sas_pkg::ADDR_CHSEL, 8'h07);
    wait_irq(n);
    chk(8'(n), sas_pkg::CONV_CYC_6);
    wr(sas_pkg::ADDR_FLAG, 8'h00);
    // The control write lands in the completion cycle, so nothing may complete
    repeat (int'(sas_pkg::CONV_CYC_6) - 4) @(posedge clk_sys_in);
    wr(sas_pkg::ADDR_CHSEL, 8'h07);
    #1 chk({7'h0, conversion_done_flag_out}, 8'h00);
    wait_irq(n);
    chk(8'(n), sas_pkg::CONV_CYC_6);
    $display("collision write done");
    repeat (20) @(posedge clk_sys_in);
    wr(sas_pkg::ADDR_MODE, 8'h30);
    p = 0;
    repeat (200) begin
      @(posedge clk_sys_in);
      #1 p += conversion_done_irq_out;
    end
    chk(8'(p), 8'h00);
    chk({7'h0, converting_out}, 8'h00);
    wr(sas_pkg::ADDR_MODE, 8'hb8);
    standby_in <= 1'b1;
    p = 0;
    repeat (300) begin
      @(posedge clk_sys_in);
      #1 p += conversion_done_irq_out;
    end
    chk(8'(p), 8'h00);
    chk({7'h0, converting_out}, 8'h00);
    standby_in <= 1'b0;
    // Leaving standby restarts from sampling; a prohibited code runs the slowest length
    wait_irq(n);
    chk(8'(n), sas_pkg::CONV_CYC_0);
    $display("stop and standby done");
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(sas_pkg::ADDR_CHSEL, d);
    chk(d, sas_pkg::CHSEL_RESET);
    rd(sas_pkg::ADDR_MODE, d);
    chk(d, sas_pkg::MODE_RESET);
    chk({7'h0, converting_out}, 8'h00);
    $display("second reset done");
    close_out();
  end
endmodule

`default_nettype wire
